//--- uref_consts.svh
// register offsets, field positions, reset values and bus codes
`ifndef UREF_CONSTS_SVH
`define UREF_CONSTS_SVH
`define UREF_ADDR_W 4
`define UREF_OFS_CTRL 4'h0
`define UREF_OFS_STATUS 4'h4
`define UREF_OFS_RXBUF 4'h8
`define UREF_CTRL_POWER_BIT 7
`define UREF_CTRL_RXE_BIT 6
`define UREF_CTRL_PAR_HI 3
`define UREF_CTRL_PAR_LO 2
`define UREF_CTRL_LEN8_BIT 1
`define UREF_CTRL_STOP2_BIT 0
`define UREF_STAT_FULL_BIT 3
`define UREF_STAT_PE_BIT 2
`define UREF_STAT_FE_BIT 1
`define UREF_STAT_OVE_BIT 0
`define UREF_RXBUF_RESET 8'hff
`define UREF_PAR_NONE 2'h0
`define UREF_PAR_ZERO 2'h1
`define UREF_PAR_ODD 2'h2
`define UREF_PAR_EVEN 2'h3
`define UREF_RESP_OKAY 2'h0
`define UREF_RESP_DECERR 2'h3
`endif

//--- uref_pkg.sv
// types shared by the receive error flag block
package uref_pkg;
  typedef struct packed {
    logic power;
    logic rx_enable;
    logic [1:0] parity_mode;
    logic len8;
    logic stop2;
  } uref_ctrl_t;
  typedef struct packed {
    logic full;
    logic parity_error_flag;
    logic framing_error_flag;
    logic overrun_error_flag;
  } uref_status_t;
  typedef struct packed {
    logic [7:0] data;
    logic parity_bit;
    logic stop_bit;
  } uref_char_t;
endpackage

//--- uref_check.sv
// parity and framing check of one received character
`timescale 1ns/1ps
`include "uref_consts.svh"
module uref_check (
  // character and its format
  input wire uref_pkg::uref_char_t ch,
  input wire logic [1:0] parity_mode,
  input wire logic len8,
  // results
  output logic parity_err,
  output logic frame_err
);
  logic odd_ones;
  always_comb begin
    odd_ones = len8 ? ^ch.data : ^ch.data[6:0];
    unique case (parity_mode)
      `UREF_PAR_NONE: parity_err = 1'b0;
      `UREF_PAR_ZERO: parity_err = ch.parity_bit;
      `UREF_PAR_ODD: parity_err = ~(odd_ones ^ ch.parity_bit);
      `UREF_PAR_EVEN: parity_err = odd_ones ^ ch.parity_bit;
    endcase
    // second stop bit never looked at, whatever the stop length
    frame_err = ~ch.stop_bit;
  end
endmodule

//--- uref_top.sv
// receive error flags of a serial port with an AXI4-Lite register slave
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "uref_consts.svh"
module uref_top (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // axi4-lite write address and data
  input wire logic [`UREF_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read
  input wire logic [`UREF_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // character from the receive shifter
  input wire logic RX_DONE,
  input wire uref_pkg::uref_char_t RX_CHAR,
  // control to the rest of the port
  output logic PORT_POWER_CONTROL,
  output logic RECEIVE_ENABLE_BIT,
  output logic STOP_LENGTH_SELECT,
  output logic RECEIVE_COMPLETE_EVENT
);
  uref_pkg::uref_ctrl_t ctrl, next_ctrl;
  uref_pkg::uref_status_t stat, next_stat;
  logic [7:0] receive_buffer_reg, next_receive_buffer_reg;
  logic rx_event, next_rx_event;
  logic aw_held, next_aw_held;
  logic w_held, next_w_held;
  logic [`UREF_ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic w_lane0, next_w_lane0;
  logic awready, next_awready;
  logic wready, next_wready;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic arready, next_arready;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  logic parity_err, frame_err;
  logic take_char, do_write, do_read, read_buf;

  uref_check u_check (
    .ch(RX_CHAR),
    .parity_mode(ctrl.parity_mode),
    .len8(ctrl.len8),
    .parity_err(parity_err),
    .frame_err(frame_err)
  );

  // a disabled or powered-down receiver ignores the shifter entirely
  assign take_char = RX_DONE & ctrl.power & ctrl.rx_enable;
  assign do_write = aw_held & w_held & ~bvalid;
  assign do_read = S_AXI_ARVALID & arready;
  assign read_buf = do_read & (S_AXI_ARADDR == `UREF_OFS_RXBUF);

  // bus handshake: address and data taken in either order
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_lane0 = w_lane0;
    next_bvalid = bvalid;
    next_bresp = bresp;
    if (S_AXI_AWVALID && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && wready) begin
      next_w_held = 1'b1;
      next_w_data = S_AXI_WDATA;
      next_w_lane0 = S_AXI_WSTRB[0];
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (aw_addr == `UREF_OFS_CTRL ||
                    aw_addr == `UREF_OFS_STATUS ||
                    aw_addr == `UREF_OFS_RXBUF) ?
                   `UREF_RESP_OKAY : `UREF_RESP_DECERR;
    end
    if (bvalid && S_AXI_BREADY) begin
      next_bvalid = 1'b0;
    end
    // no new write accepted until the response is gone
    next_awready = ~next_aw_held & ~next_bvalid;
    next_wready = ~next_w_held & ~next_bvalid;
  end

  // read channel: answer one cycle after the address is taken
  always_comb begin
    next_arready = arready;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (do_read) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rresp = `UREF_RESP_OKAY;
      unique case (S_AXI_ARADDR)
        `UREF_OFS_CTRL: next_rdata = {24'h000000, ctrl.power,
                                      ctrl.rx_enable, 2'h0,
                                      ctrl.parity_mode, ctrl.len8,
                                      ctrl.stop2};
        `UREF_OFS_STATUS: next_rdata = {28'h0000000, stat};
        `UREF_OFS_RXBUF: next_rdata = {24'h000000, receive_buffer_reg};
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = `UREF_RESP_DECERR;
        end
      endcase
    end else if (rvalid && S_AXI_RREADY) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
  end

  // control register, byte lane 0 only
  always_comb begin
    next_ctrl = ctrl;
    if (do_write && aw_addr == `UREF_OFS_CTRL && w_lane0) begin
      next_ctrl.power = w_data[`UREF_CTRL_POWER_BIT];
      next_ctrl.rx_enable = w_data[`UREF_CTRL_RXE_BIT];
      next_ctrl.parity_mode = w_data[`UREF_CTRL_PAR_HI:`UREF_CTRL_PAR_LO];
      next_ctrl.len8 = w_data[`UREF_CTRL_LEN8_BIT];
      next_ctrl.stop2 = w_data[`UREF_CTRL_STOP2_BIT];
    end
  end

  // status flags and receive buffer
  always_comb begin
    next_stat = stat;
    next_receive_buffer_reg = receive_buffer_reg;
    if (do_write && aw_addr == `UREF_OFS_STATUS && w_lane0) begin
      // and-ing with the written bit: zero clears, one keeps
      next_stat.parity_error_flag = stat.parity_error_flag &
                                    w_data[`UREF_STAT_PE_BIT];
      next_stat.framing_error_flag = stat.framing_error_flag &
                                     w_data[`UREF_STAT_FE_BIT];
      next_stat.overrun_error_flag = stat.overrun_error_flag &
                                     w_data[`UREF_STAT_OVE_BIT];
    end
    if (read_buf) begin
      next_stat.full = 1'b0;
    end
    // detection after the clear so a same-cycle event is never lost
    if (take_char) begin
      if (parity_err) begin
        next_stat.parity_error_flag = 1'b1;
      end
      if (frame_err) begin
        next_stat.framing_error_flag = 1'b1;
      end
      // unread character still in the buffer: keep it, drop the new one
      if (stat.full && !read_buf) begin
        next_stat.overrun_error_flag = 1'b1;
      end else begin
        next_receive_buffer_reg = RX_CHAR.data;
        next_stat.full = 1'b1;
      end
    end
    // next control value so the flags drop at the same edge as the bit
    if (!next_ctrl.power || !next_ctrl.rx_enable) begin
      next_stat.parity_error_flag = 1'b0;
      next_stat.framing_error_flag = 1'b0;
      next_stat.overrun_error_flag = 1'b0;
      next_stat.full = 1'b0;
    end
    if (!next_ctrl.power) begin
      next_receive_buffer_reg = `UREF_RXBUF_RESET;
    end
    // event on every taken character, good or in error
    next_rx_event = take_char;
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ctrl <= '0;
      stat <= '0;
      receive_buffer_reg <= `UREF_RXBUF_RESET;
      rx_event <= 1'b0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h00000000;
      w_lane0 <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `UREF_RESP_OKAY;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `UREF_RESP_OKAY;
    end else begin
      ctrl <= next_ctrl;
      stat <= next_stat;
      receive_buffer_reg <= next_receive_buffer_reg;
      rx_event <= next_rx_event;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_lane0 <= next_w_lane0;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  assign S_AXI_AWREADY = awready;
  assign S_AXI_WREADY = wready;
  assign S_AXI_BVALID = bvalid;
  assign S_AXI_BRESP = bresp;
  assign S_AXI_ARREADY = arready;
  assign S_AXI_RVALID = rvalid;
  assign S_AXI_RDATA = rdata;
  assign S_AXI_RRESP = rresp;
  assign PORT_POWER_CONTROL = ctrl.power;
  assign RECEIVE_ENABLE_BIT = ctrl.rx_enable;
  assign STOP_LENGTH_SELECT = ctrl.stop2;
  assign RECEIVE_COMPLETE_EVENT = rx_event;
endmodule

//--- uref_top_asserts.sv
// concurrent checks on the receive flag block ports
`timescale 1ns/1ps
`include "uref_consts.svh"
module uref_top_asserts (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // read channel
  input wire logic [`UREF_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // receive side
  input wire logic RX_DONE,
  input wire logic PORT_POWER_CONTROL,
  input wire logic RECEIVE_ENABLE_BIT,
  input wire logic RECEIVE_COMPLETE_EVENT
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  wire ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
  wire rx_on = RX_DONE && PORT_POWER_CONTROL && RECEIVE_ENABLE_BIT;
  sequence stat_rd;
    ar_take && S_AXI_ARADDR == `UREF_OFS_STATUS;
  endsequence
  sequence buf_rd;
    ar_take && S_AXI_ARADDR == `UREF_OFS_RXBUF;
  endsequence
  event_fire_a: assert property (rx_on |=> RECEIVE_COMPLETE_EVENT)
    else $error("receive event missing");
  event_quiet_a: assert property (!rx_on |=> !RECEIVE_COMPLETE_EVENT)
    else $error("receive event without character");
  pe_unpowered_a: assert property (stat_rd ##0 !PORT_POWER_CONTROL |=>
    !S_AXI_RDATA[`UREF_STAT_PE_BIT]) else $error("parity flag kept");
  pe_disabled_a: assert property (stat_rd ##0 !RECEIVE_ENABLE_BIT |=>
    !S_AXI_RDATA[`UREF_STAT_PE_BIT]) else $error("parity flag kept");
  buf_ones_a: assert property (buf_rd ##0 !PORT_POWER_CONTROL |=>
    S_AXI_RDATA[7:0] == `UREF_RXBUF_RESET) else $error("buffer not ones");
  read_answer_a: assert property (ar_take |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("read answer late");
  read_close_a: assert property (S_AXI_RVALID && S_AXI_RREADY |=>
    !S_AXI_RVALID && S_AXI_ARREADY) else $error("read not closed");
  unmapped_rd_a: assert property (ar_take && S_AXI_ARADDR == 4'hc |=>
    S_AXI_RRESP == `UREF_RESP_DECERR && S_AXI_RDATA == 32'h0)
    else $error("unmapped read answered");
endmodule

//--- uref_sender.sv
// behavioural remote transmitter handing finished characters over
`timescale 1ns/1ps
module uref_sender (
  // clock
  input wire logic clk,
  // finished character
  output logic rx_done,
  output uref_pkg::uref_char_t rx_char
);
  initial begin
    rx_done = 1'b0;
    rx_char = '0;
  end
  // payload inverted when idle so a stale character never looks fresh
  task automatic send(input logic [7:0] d, input logic p, input logic s);
    rx_done <= 1'b1;
    rx_char <= {d, p, s};
    @(posedge clk);
    rx_done <= 1'b0;
    rx_char <= ~rx_char;
    @(posedge clk);
  endtask
endmodule

//--- test_uref_top.sv
// self-checking bench for the receive error flag block
`timescale 1ns/1ps
`include "uref_consts.svh"
module test_uref_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  wire awready, wready, bvalid, arready, rvalid, done, pwr, rxe, stop2, evt;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  uref_pkg::uref_char_t rxc;
  int mismatches = 0;
  int checks = 0;
  int evt_count = 0;
  always #5 clk = ~clk;
  // one count per high cycle, so a pulse that stands too long shows
  always @(posedge clk) if (evt === 1'b1) evt_count++;
  uref_top u_uref_top (.REF_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .RX_DONE(done), .RX_CHAR(rxc),
    .PORT_POWER_CONTROL(pwr), .RECEIVE_ENABLE_BIT(rxe),
    .STOP_LENGTH_SELECT(stop2), .RECEIVE_COMPLETE_EVENT(evt));
  uref_sender u_uref_sender (.clk(clk), .rx_done(done), .rx_char(rxc));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // address and data offered together, each dropped once taken
  task automatic wrc(input logic [3:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    do @(posedge clk); while (!bvalid);
    chk({30'h0, bresp}, (a > `UREF_OFS_RXBUF) ? 32'h3 : 32'h0);
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d,
    output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
  endtask
  // every parity mode, one data bit set and parity bit high
  task automatic t_modes;
    logic [7:0] d;
    logic e;
    d = 8'h01;
    rdchk(`UREF_OFS_RXBUF, 32'hff);
    for (int i = 0; i < 4; i++) begin
      e = (i == 1) || (i == 2 && ^d) || (i == 3 && !(^d));
      wrc(`UREF_OFS_CTRL, {24'h0, 4'hc, i[1:0], 2'h2});
      u_uref_sender.send(d, 1'b1, 1'b1);
      rdchk(`UREF_OFS_STATUS, {28'h0, 1'b1, e, 2'h0});
      rdchk(`UREF_OFS_RXBUF, {24'h0, d});
      wrc(`UREF_OFS_STATUS, 32'h0);
    end
    // 7-bit even parity: bit 7 must stay out of the sum
    wrc(`UREF_OFS_CTRL, 32'hcc);
    u_uref_sender.send(8'h81, 1'b1, 1'b1);
    rdchk(`UREF_OFS_STATUS, 32'h8);
    rdchk(`UREF_OFS_RXBUF, 32'h81);
    $display("test parity modes done");
  endtask
  task automatic t_sticky;
    wrc(`UREF_OFS_CTRL, 32'hcf);
    u_uref_sender.send(8'h55, 1'b1, 1'b0);
    rdchk(`UREF_OFS_STATUS, 32'he);
    chk({31'h0, stop2}, 32'h1);
    wrc(`UREF_OFS_STATUS, 32'hff);
    rdchk(`UREF_OFS_STATUS, 32'he);
    wrc(`UREF_OFS_STATUS, 32'h3);
    rdchk(`UREF_OFS_STATUS, 32'ha);
    u_uref_sender.send(8'h33, 1'b0, 1'b1);
    rdchk(`UREF_OFS_STATUS, 32'hb);
    rdchk(`UREF_OFS_RXBUF, 32'h55);
    rdchk(`UREF_OFS_STATUS, 32'h3);
    $display("test sticky flags done");
  endtask
  task automatic t_disable;
    logic [31:0] d;
    logic [1:0] r;
    u_uref_sender.send(8'h55, 1'b1, 1'b1);
    rdchk(`UREF_OFS_STATUS, 32'hf);
    wrc(`UREF_OFS_CTRL, 32'h8e);
    rdchk(`UREF_OFS_STATUS, 32'h0);
    wrc(`UREF_OFS_CTRL, 32'hce);
    u_uref_sender.send(8'h55, 1'b1, 1'b1);
    rdchk(`UREF_OFS_STATUS, 32'hc);
    wrc(`UREF_OFS_CTRL, 32'h4e);
    chk({30'h0, pwr, rxe}, 32'h1);
    rdchk(`UREF_OFS_STATUS, 32'h0);
    rdchk(`UREF_OFS_RXBUF, 32'hff);
    u_uref_sender.send(8'h12, 1'b0, 1'b1);
    rdchk(`UREF_OFS_RXBUF, 32'hff);
    wrc(4'hc, 32'h0);
    rd(4'hc, d, r);
    chk({30'h0, r}, 32'h3);
    // nine characters taken, errors and overrun included; one ignored
    chk(evt_count, 32'h9);
    $display("test disable and power done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_modes;
    t_sticky;
    t_disable;
    results;
  end
  // whole run needs a few hundred cycles; a hang is cut well beyond that
  initial begin
    #100000;
    mismatches++;
    results;
  end
endmodule
bind uref_top uref_top_asserts u_uref_top_asserts (.REF_CLK(REF_CLK),
  .RST(RST), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .RX_DONE(RX_DONE),
  .PORT_POWER_CONTROL(PORT_POWER_CONTROL),
  .RECEIVE_ENABLE_BIT(RECEIVE_ENABLE_BIT),
  .RECEIVE_COMPLETE_EVENT(RECEIVE_COMPLETE_EVENT));
